// File: design/blc_ctrl_pkg.sv
// Package: layout, reset value and modes of the black level control register
package blc_ctrl_pkg;

	// ****************************************************************
	// Register layout
	// ****************************************************************
	localparam int          RegWidth      = 16;
	localparam logic [15:0] CtrlReset     = 16'h07f8;
	localparam int          BitSkipSweep  = 15;
	localparam int          BitRestart    = 12;
	localparam int          BitKeepThresh = 11;
	localparam int          ModeHi        = 2;
	localparam int          ModeLo        = 1;
	localparam int          BitOverride   = 0;
	localparam logic [15:0] RsvdOnesMask  = 16'h07f8;
	localparam logic [15:0] RsvdZeroMask  = 16'h6000;
	localparam logic [15:0] WritableMask  = 16'h8807;

	// ****************************************************************
	// Calibration application modes
	// ****************************************************************
	typedef enum logic [1:0] {
		ApplyAdcOnly,
		ApplyAlways,
		ApplyNever
	} apply_mode_type;

endpackage : blc_ctrl_pkg

// File: design/blc_sweep_seq.sv
// Sweep sequencer: one sweep request per trigger, answers with a done pulse
module blc_sweep_seq
	import blc_ctrl_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	typedef enum logic {Idle, Sweep} sweep_state_type;

	sweep_state_type stateReg;
	sweep_state_type stateNext;
	logic            doneReg;
	logic            doneNext;
	logic            busyReg;
	logic            busyNext;

	// Next state: a sweep lasts one cycle, then reports completion
	always_comb begin
		stateNext = stateReg;
		doneNext  = 1'b0;
		case (stateReg)
			Idle: begin
				if (start) begin
					stateNext = Sweep;
				end
			end
			Sweep: begin
				stateNext = Idle;
				doneNext  = 1'b1;
			end
			default: begin
				stateNext = Idle;
			end
		endcase
		// Busy is registered so the output comes straight from a flop
		busyNext = (stateNext == Sweep);
	end

	// State registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stateReg <= Idle;
			doneReg  <= 1'b0;
			busyReg  <= 1'b0;
		end else begin
			stateReg <= stateNext;
			doneReg  <= doneNext;
			busyReg  <= busyNext;
		end
	end

	assign busy = busyReg;
	assign done = doneReg;

endmodule : blc_sweep_seq

// File: design/black_level_calib_control.sv
// Black level calibration control register and its control outputs
//
// Function
// - Writing one to bit 12 restarts filtered average and triggers a rapid sweep.
// - Bit 12 never stores; it reads back zero, even in the cycle the restart is accepted.
// - Bit 11 one keeps upper threshold after sweep; zero resets it.
// - Mode field 00 applies calibration only during converter operation.
// - Mode field 10 applies calibration continuously.
// - Mode bit 1 set disables correction and forces offsets to zero.
// - Bit 0 one selects host programmed correction values over automatic ones.
// - Reserved bits 10 to 3 reset to one; host writes ones.
// - Reserved bits 14 and 13 reset to zero; host writes zeros.
// - Bit 15 one skips the rapid sweep on new gain settings.
module black_level_calib_control
	import blc_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wrEn,
	input  wire logic [15:0] wrData,
	input  wire logic        adcActive,
	input  wire logic        gainChanged,
	input  wire logic [9:0]  progOffset,
	input  wire logic [9:0]  autoOffset,
	output logic [15:0]      rdData,
	output logic             avgRestart,
	output logic             sweepStart,
	output logic             sweepActive,
	output logic             threshReset,
	output logic             calibApply,
	output logic             correctEnable,
	output logic [9:0]       offsetValue,
	output logic [9:0]       skewValue
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [15:0]    ctrlReg;
	logic [15:0]    ctrlNext;
	logic           restartReg;
	logic           restartNext;
	logic           sweepReg;
	logic           sweepNext;
	logic           threshReg;
	logic           threshNext;
	logic           applyReg;
	logic           applyNext;
	logic           enableReg;
	logic           enableNext;
	logic [9:0]     offsetReg;
	logic [9:0]     offsetNext;
	logic [9:0]     skewReg;
	logic [9:0]     skewNext;
	logic           seqBusy;
	logic           seqDone;
	apply_mode_type mode;

	// Write path; reserved bits are held at their defaults whatever arrives
	always_comb begin
		ctrlNext = ctrlReg;
		ctrlNext[BitRestart] = 1'b0;
		if (wrEn) begin
			ctrlNext = (wrData & WritableMask) | RsvdOnesMask;
			ctrlNext[BitRestart] = 1'b0;
		end
	end

	// Restart pulse taken straight from the write so the bit never stores
	always_comb begin
		restartNext = wrEn & wrData[BitRestart];
	end

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	// Bit 1 overrides bit 2, so X1 always means disabled
	always_comb begin
		if (ctrlReg[ModeLo]) begin
			mode = ApplyNever;
		end else if (ctrlReg[ModeHi]) begin
			mode = ApplyAlways;
		end else begin
			mode = ApplyAdcOnly;
		end
	end

	// Sweep request: restart always sweeps, gain change unless suppressed
	always_comb begin
		sweepNext = restartNext;
		if (gainChanged && !ctrlReg[BitSkipSweep]) begin
			sweepNext = 1'b1;
		end
		// Threshold reset only when not told to keep it
		threshNext = seqDone & ~ctrlReg[BitKeepThresh];
	end

	// Application and correction outputs
	always_comb begin
		applyNext  = 1'b0;
		enableNext = 1'b1;
		offsetNext = ctrlReg[BitOverride] ? progOffset : autoOffset;
		skewNext   = offsetNext;
		case (mode)
			ApplyAdcOnly: applyNext = adcActive;
			ApplyAlways:  applyNext = 1'b1;
			ApplyNever: begin
				enableNext = 1'b0;
				offsetNext = 10'h000;
				skewNext   = 10'h000;
			end
			default: applyNext = 1'b0;
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrlReg    <= CtrlReset;
			restartReg <= 1'b0;
			sweepReg   <= 1'b0;
			threshReg  <= 1'b0;
			applyReg   <= 1'b0;
			enableReg  <= 1'b0;
			offsetReg  <= 10'h000;
			skewReg    <= 10'h000;
		end else begin
			ctrlReg    <= ctrlNext;
			restartReg <= restartNext;
			sweepReg   <= sweepNext;
			threshReg  <= threshNext;
			applyReg   <= applyNext;
			enableReg  <= enableNext;
			offsetReg  <= offsetNext;
			skewReg    <= skewNext;
		end
	end

	// Sweep sequencer, started by the registered request
	blc_sweep_seq sweepSeq (
		.clk   (clk),
		.rst_n (rst_n),
		.start (sweepReg),
		.busy  (seqBusy),
		.done  (seqDone)
	);

	// Outputs, all from flip-flops
	assign rdData        = ctrlReg;
	assign avgRestart    = restartReg;
	assign sweepStart    = sweepReg;
	assign sweepActive   = seqBusy;
	assign threshReset   = threshReg;
	assign calibApply    = applyReg;
	assign correctEnable = enableReg;
	assign offsetValue   = offsetReg;
	assign skewValue     = skewReg;

endmodule : black_level_calib_control

// File: verif/blc_host_model.sv
// Host model: writes the control word as a serial host would
module blc_host_model
	import blc_ctrl_pkg::*;
(
	input  wire logic  clk,
	output logic       wrEn,
	output logic[15:0] wrData
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		wrEn = 1'b0;
		wrData = CtrlReset;
	end
	// One-cycle write; idle bus shows junk so stale data never matches
	task automatic write(input logic [15:0] v);
		@(posedge clk) #1;
		wrEn = 1'b1;
		// Restart command bit must pass, or no restart is ever issued
		wrData = (v & (WritableMask | (16'h0001 << BitRestart)))
			| RsvdOnesMask;
		@(posedge clk) #1;
		wrEn = 1'b0;
		wrData = ~wrData;
	endtask : write
endmodule : blc_host_model

// File: verif/blc_ctrl_sva.sv
// Checker: port assertions for the calibration control register
module blc_ctrl_sva
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       wrEn,
	input wire logic[15:0] wrData,
	input wire logic       adcActive,
	input wire logic       gainChanged,
	input wire logic[9:0]  progOffset,
	input wire logic[9:0]  autoOffset,
	input wire logic[15:0] rdData,
	input wire logic       avgRestart,
	input wire logic       sweepStart,
	input wire logic       sweepActive,
	input wire logic       threshReset,
	input wire logic       calibApply,
	input wire logic       correctEnable,
	input wire logic[9:0]  offsetValue,
	input wire logic[9:0]  skewValue
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_restart_pulse: assert property (wrEn && wrData[12] |=> avgRestart && sweepStart) else $error("no restart");
	a_sweep_busy: assert property (sweepStart && !sweepActive |=> sweepActive) else $error("sweep not started");
	a_restart_clear: assert property (!rdData[12]) else $error("bit 12 kept");
	a_thresh_reset: assert property (sweepStart && !rdData[11] && !wrEn |-> ##3 threshReset) else $error("no thresh reset");
	a_thresh_keep: assert property (sweepStart && rdData[11] |-> ##3 !threshReset) else $error("thresh reset");
	a_adc_only: assert property ($past(rst_n) && rdData[2:1] == 2'b00 && $past(rdData[2:1]) == 2'b00 |-> calibApply == $past(adcActive)) else $error("adc mode");
	a_apply_cont: assert property (rdData[2:1] == 2'b10 && $past(rdData[2:1]) == 2'b10 |-> calibApply) else $error("continuous");
	a_cal_off: assert property (rdData[1] && $past(rdData[1]) |-> !calibApply && !correctEnable && offsetValue == 10'h0 && skewValue == 10'h0) else $error("disable");
	a_override_sel: assert property ($past(rst_n) && !rdData[1] && $past(rdData[1:0]) == rdData[1:0] |-> offsetValue == (rdData[0] ? $past(progOffset) : $past(autoOffset))) else $error("override");
	a_skip_sweep: assert property (gainChanged && !wrEn && rdData[15] |=> !sweepStart) else $error("sweep");
	a_gain_sweep: assert property (gainChanged && !wrEn && !rdData[15] |=> sweepStart) else $error("no sweep");
	a_rsvd_bits: assert property ((rdData & 16'h67f8) == 16'h07f8) else $error("reserved");
endmodule : blc_ctrl_sva
bind black_level_calib_control blc_ctrl_sva chk (.clk(clk), .rst_n(rst_n),
	.wrEn(wrEn), .wrData(wrData), .adcActive(adcActive),
	.gainChanged(gainChanged), .progOffset(progOffset),
	.autoOffset(autoOffset), .rdData(rdData), .avgRestart(avgRestart),
	.sweepStart(sweepStart), .sweepActive(sweepActive),
	.threshReset(threshReset),
	.calibApply(calibApply), .correctEnable(correctEnable),
	.offsetValue(offsetValue), .skewValue(skewValue));

// File: verif/black_level_calib_control_tb_top.sv
// Testbench: host writes exercise the calibration control register
module black_level_calib_control_tb_top;
	import blc_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [9:0] Prog = 10'h155;
	localparam logic [9:0] Auto = 10'h2aa;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        adc = 1'b0;
	logic        gain = 1'b0;
	logic        wrEn, avgR, swS, swA, thR, calA, corE;
	logic [15:0] wrData, rdData;
	logic [9:0]  offV, skewV;
	int          err_count = 0;
	int          n_tests = 0;
	always #12.5 clk = ~clk;
	blc_host_model host (.clk(clk), .wrEn(wrEn), .wrData(wrData));
	black_level_calib_control dut (.clk(clk), .rst_n(rst_n), .wrEn(wrEn),
		.wrData(wrData), .adcActive(adc), .gainChanged(gain),
		.progOffset(Prog), .autoOffset(Auto), .rdData(rdData),
		.avgRestart(avgR), .sweepStart(swS), .sweepActive(swA),
		.threshReset(thR),
		.calibApply(calA), .correctEnable(corE), .offsetValue(offV),
		.skewValue(skewV));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Restart pulses, then threshold reset three cycles on unless kept
	task automatic t_restart(input logic [15:0] v);
		host.write(v);
		chk(16'({avgR, swS, rdData[12]}), 16'h6);
		tick(1);
		chk(16'(swA), 16'h1);
		tick(2);
		chk(16'(thR), 16'(!v[11]));
		$display("restart test done");
	endtask : t_restart
	// All mode and override codes, with the converter idle and running
	task automatic t_modes;
		for (int i = 0; i < 16; i++) begin
			adc = i[3];
			host.write(16'(i[2:0]));
			tick(1);
			chk(16'({calA, corE}), 16'({!i[1] && (i[2] || i[3]), !i[1]}));
			chk(16'(offV), i[1] ? 16'h0 : 16'(i[0] ? Prog : Auto));
			chk(16'(skewV), i[1] ? 16'h0 : 16'(i[0] ? Prog : Auto));
		end
		$display("mode test done");
	endtask : t_modes
	// Gain change sweeps only while skip bit is clear
	task automatic t_gain(input logic [15:0] v);
		host.write(v);
		gain = 1'b1;
		tick(1);
		gain = 1'b0;
		chk(16'(swS), 16'(!v[15]));
		tick(4);
		$display("gain test done");
	endtask : t_gain
	initial begin
		tick(12);
		rst_n = 1'b1;
		chk(rdData, CtrlReset);
		host.write(16'hffff);
		chk(rdData, 16'h8fff);
		tick(4);
		t_restart(16'h1000);
		t_restart(16'h1800);
		t_modes;
		t_gain(16'h8000);
		t_gain(16'h0000);
		test_done;
	end
	// Watchdog cuts a hang short
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		test_done;
	end
endmodule : black_level_calib_control_tb_top
